//--- src/psw_pkg.sv
// Package of constants and types for the status word swap unit
package psw_pkg;
	// ****************************************
	// Status word bit positions (bit 0 is the most significant)
	// ****************************************
	localparam int PSW_W = 64;
	localparam int BIT_FXOVF_MASK = 20;
	localparam int BIT_UNFL_MASK = 22;
	localparam int BIT_SIGN_MASK = 23;
	localparam int BIT_MON_MASK = 34;
	localparam int BIT_EAHI_FIRST = 40;
	localparam int BIT_MC_MASK = 43;
	localparam int BIT_WAIT = 46;
	localparam int BIT_PROBLEM = 47;
	localparam int BIT_CODE_FIRST = 48;
	localparam int SYS_LEVELS = 7;
	localparam int BIT_SYS_FIRST = 32;

	// ****************************************
	// Program exception causes (index into a cause vector)
	// ****************************************
	localparam int PC_N = 8;
	localparam int PC_FXOVF = 0;
	localparam int PC_UNFL = 1;
	localparam int PC_SIGN = 2;
	localparam int PC_MON = 3;
	localparam int PC_PROT = 4;
	localparam int PC_PRIV = 5;
	localparam int PC_ILLINST = 6;
	localparam int PC_ILLADDR = 7;

	// ****************************************
	// Preferred storage area, halfword addresses of old and new words
	// ****************************************
	localparam logic [15:0] PSA_MC_OLD = 16'h0040;
	localparam logic [15:0] PSA_MC_NEW = 16'h0044;
	localparam logic [15:0] PSA_PGM_OLD = 16'h0048;
	localparam logic [15:0] PSA_PGM_NEW = 16'h004c;
	localparam logic [15:0] PSA_SVC_OLD = 16'h0058;
	localparam logic [15:0] PSA_SVC_NEW = 16'h005c;
	localparam logic [15:0] PSA_SYS_OLD = 16'h0060;
	localparam logic [15:0] PSA_SYS_STEP = 16'h0008;
	localparam logic [15:0] PSA_PWR_ON = 16'h0020;
	localparam logic [15:0] PSA_PUTAWAY = 16'h0100;
	localparam logic [7:0] PUTAWAY_WORDS = 8'h30;

	// Interrupt codes placed in the low field of the old word
	localparam logic [15:0] CODE_MC = 16'h0008;
	localparam logic [15:0] CODE_PGM_BASE = 16'h0000;

	// ****************************************
	// Register map on APB (byte addresses)
	// ****************************************
	localparam logic [7:0] A_PSW_HI = 8'h00;
	localparam logic [7:0] A_PSW_LO = 8'h04;
	localparam logic [7:0] A_STATUS = 8'h08;
	localparam logic [7:0] A_MASK = 8'h0c;
	localparam logic [7:0] A_CTRL = 8'h10;
	localparam logic [7:0] A_SYSPEND = 8'h14;
	localparam int EV_N = 5;
	localparam int EV_MC = 0;
	localparam int EV_PGM = 1;
	localparam int EV_SVC = 2;
	localparam int EV_SYS = 3;
	localparam int EV_PWR = 4;
	localparam logic [63:0] PSW_RESET = 64'h0;

	// ****************************************
	// Swap sequencer states, one-hot
	// ****************************************
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_OLDHI = 7'h02,
		ST_OLDLO = 7'h04,
		ST_NEWHI = 7'h08,
		ST_NEWLO = 7'h10,
		ST_PUT = 7'h20,
		ST_DOWN = 7'h40
	} psw_state_t;

	// Which class a swap serves
	typedef enum logic [4:0] {
		CL_MC = 5'h01,
		CL_PGM = 5'h02,
		CL_SVC = 5'h04,
		CL_SYS = 5'h08,
		CL_PWR = 5'h10
	} psw_class_t;

	// Map big-endian status word bit number to vector index
	function automatic int unsigned pbit(input int unsigned n);
		return PSW_W - 1 - n;
	endfunction
endpackage

//--- src/psw_mask.sv
// Masking of program and system requests
`timescale 1ns/1ns
module psw_mask
	import psw_pkg::*;
(
	input wire logic [63:0] psw,
	input wire logic [PC_N-1:0] pgm_cause,
	input wire logic [SYS_LEVELS-1:0] sys_pend,
	output logic [PC_N-1:0] pgm_take,
	output logic [SYS_LEVELS-1:0] sys_take
);
	// Masked program causes are simply dropped here
	always_comb begin
		pgm_take = pgm_cause;
		pgm_take[PC_FXOVF] = pgm_cause[PC_FXOVF] & psw[pbit(BIT_FXOVF_MASK)]; // RL9
		pgm_take[PC_UNFL] = pgm_cause[PC_UNFL] & psw[pbit(BIT_UNFL_MASK)]; // RL9
		pgm_take[PC_SIGN] = pgm_cause[PC_SIGN] & psw[pbit(BIT_SIGN_MASK)]; // RL9
		pgm_take[PC_MON] = pgm_cause[PC_MON] & psw[pbit(BIT_MON_MASK)]; // RL10
		pgm_take[PC_PROT] = pgm_cause[PC_PROT] & psw[pbit(BIT_MC_MASK)]; // RL11
		// Invalid instruction and address are never masked
		pgm_take[PC_ILLINST] = pgm_cause[PC_ILLINST]; // RL13
		pgm_take[PC_ILLADDR] = pgm_cause[PC_ILLADDR]; // RL13
	end

	// System levels pass only where their mask bit is set
	always_comb begin
		for (int i = 0; i < SYS_LEVELS; i++) begin
			sys_take[i] = sys_pend[i] & psw[pbit(BIT_SYS_FIRST + i)];
		end
	end
endmodule

//--- src/psw_swap_unit.sv
// Status word holder and interrupt swap sequencer
//
// Summary of operation
// RL1: Bit 46 one means wait, zero run.
// RL2: Bit 47 zero is supervisor; privileged allowed.
// RL3: Problem state blocks privileged op, raises interrupt.
// RL4: Bits 48-63 hold the interrupt code.
// RL5: Power loss saves machine state to storage.
// RL6: Power return in run mode loads power-on word.
// RL7: Unmasked malfunction ends instruction, takes interrupt.
// RL8: Masked machine check is discarded.
// RL9: Bits 20, 22, 23 enable arithmetic exceptions.
// RL10: Bit 34 enables instruction monitor interrupt.
// RL11: Bit 43 also masks store protect violation.
// RL12: Masked program interrupt is dropped.
// RL13: Invalid instruction or address always taken.
// RL14: Call puts high address bits into 40-43.
// RL15: Call puts 16-bit address into code field.
// RL16: Call may enter supervisor via new word.
// RL17: Swap stores old word, loads new word.
// RL18: Masked system interrupts stay pending.
// RL19: Old word fully stored before new fetched.
`timescale 1ns/1ns
module psw_swap_unit
	import psw_pkg::*;
(
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic CE,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic IRQ,
	// Processor side events, same clock
	input wire logic MALFUNCTION,
	input wire logic [PC_N-1:0] PGM_CAUSE,
	input wire logic PRIV_OP,
	input wire logic SVC_EXEC,
	input wire logic [18:0] SVC_EA,
	input wire logic ENDOP,
	// Pins from outside
	input wire logic POWER_GOOD,
	input wire logic RUN_MODE,
	input wire logic [SYS_LEVELS-1:0] SYS_REQ,
	// Processor control
	output logic CPU_WAIT,
	output logic CPU_SUPERVISOR,
	output logic PRIV_EXEC_OK,
	output logic TERMINATE,
	output logic PUTAWAY_REQ,
	output logic [15:0] PUTAWAY_ADDR,
	// Storage port, one 32-bit access per cycle
	output logic MEM_REQ,
	output logic MEM_WE,
	output logic [15:0] MEM_ADDR,
	output logic [31:0] MEM_WDATA,
	input wire logic [31:0] MEM_RDATA,
	input wire logic MEM_ACK
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [63:0] psw_reg; // Current status word
		psw_state_t st_reg; // Sequencer state
		psw_class_t cls_reg; // Class being served
		logic [15:0] old_a_reg; // Old word address
		logic [15:0] new_a_reg; // New word address
		logic [63:0] save_reg; // Word being stored
		logic [SYS_LEVELS-1:0] sys_pend_reg; // Pending system levels
		logic [EV_N-1:0] stat_reg; // Sticky event bits
		logic [EV_N-1:0] mask_reg; // Interrupt mask
		logic [7:0] put_cnt_reg; // Putaway word count
		logic pwr_down_reg; // Machine is powered down
		logic [SYS_LEVELS+1:0] sync1_reg; // First sync stage
		logic [SYS_LEVELS+1:0] sync2_reg; // Second sync stage
		logic [31:0] rdata_reg; // Read data
		logic term_reg; // Terminate pulse
	} psw_regs_t;

	psw_regs_t r_reg;
	psw_regs_t r_next;
	logic [PC_N-1:0] pgm_all;
	logic [PC_N-1:0] pgm_take;
	logic [SYS_LEVELS-1:0] sys_take;
	logic pwr_good_s;
	logic run_mode_s;
	logic apb_acc;
	logic [EV_N-1:0] ev;
	logic [2:0] sys_lvl;
	logic mc_take;

	assign pwr_good_s = r_reg.sync2_reg[SYS_LEVELS];
	assign run_mode_s = r_reg.sync2_reg[SYS_LEVELS+1];
	// Privileged op in problem state is a program cause
	always_comb begin
		pgm_all = PGM_CAUSE;
		pgm_all[PC_PRIV] = PGM_CAUSE[PC_PRIV] | (PRIV_OP & r_reg.psw_reg[pbit(BIT_PROBLEM)]); // RL3
	end

	// ****************************************
	// Mask logic
	// ****************************************
	psw_mask u_mask (
		.psw(r_reg.psw_reg),
		.pgm_cause(pgm_all),
		.sys_pend(r_reg.sys_pend_reg),
		.pgm_take(pgm_take),
		.sys_take(sys_take)
	);

	// Lowest numbered pending system level whose mask bit is set
	always_comb begin
		sys_lvl = 3'h0;
		for (int i = SYS_LEVELS - 1; i >= 0; i--) begin
			if (sys_take[i]) begin
				sys_lvl = 3'(i);
			end
		end
	end

	assign mc_take = MALFUNCTION & r_reg.psw_reg[pbit(BIT_MC_MASK)]; // RL8
	assign apb_acc = PSEL & PENABLE;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		r_next = r_reg;
		ev = '0;
		r_next.term_reg = 1'b0;
		r_next.sync1_reg = {RUN_MODE, POWER_GOOD, SYS_REQ};
		r_next.sync2_reg = r_reg.sync1_reg;
		// Masked system requests stay latched until taken
		r_next.sys_pend_reg = r_reg.sys_pend_reg | r_reg.sync2_reg[SYS_LEVELS-1:0]; // RL18
		case (r_reg.st_reg)
			ST_IDLE: begin
				if (!pwr_good_s && !r_reg.pwr_down_reg) begin
					// Power loss: put away state first
					r_next.st_reg = ST_PUT; // RL5
					r_next.put_cnt_reg = 8'h00;
					r_next.cls_reg = CL_PWR;
					ev[EV_PWR] = 1'b1;
				end else if (r_reg.pwr_down_reg) begin
					if (pwr_good_s && run_mode_s) begin
						r_next.pwr_down_reg = 1'b0;
						r_next.new_a_reg = PSA_PWR_ON; // RL6
						r_next.cls_reg = CL_PWR;
						r_next.st_reg = ST_NEWHI;
					end
				end else if (mc_take) begin
					r_next.term_reg = 1'b1; // RL7
					r_next.save_reg = r_reg.psw_reg;
					r_next.save_reg[15:0] = CODE_MC; // RL4
					r_next.old_a_reg = PSA_MC_OLD;
					r_next.new_a_reg = PSA_MC_NEW;
					r_next.cls_reg = CL_MC;
					r_next.st_reg = ST_OLDHI;
					ev[EV_MC] = 1'b1;
				end else if (|pgm_take) begin
					// Masked causes never reach here and are not kept
					r_next.save_reg = r_reg.psw_reg; // RL12
					for (int i = PC_N - 1; i >= 0; i--) begin
						if (pgm_take[i]) begin
							r_next.save_reg[15:0] = CODE_PGM_BASE + 16'(i); // RL4
						end
					end
					r_next.old_a_reg = PSA_PGM_OLD;
					r_next.new_a_reg = PSA_PGM_NEW;
					r_next.cls_reg = CL_PGM;
					r_next.st_reg = ST_OLDHI;
					ev[EV_PGM] = 1'b1;
				end else if (SVC_EXEC) begin
					r_next.save_reg = r_reg.psw_reg;
					r_next.save_reg[pbit(BIT_EAHI_FIRST) -: 4] = SVC_EA[18:15]; // RL14
					r_next.save_reg[15:0] = SVC_EA[15:0]; // RL15
					r_next.old_a_reg = PSA_SVC_OLD;
					r_next.new_a_reg = PSA_SVC_NEW;
					r_next.cls_reg = CL_SVC;
					r_next.st_reg = ST_OLDHI;
					ev[EV_SVC] = 1'b1;
				end else if (ENDOP && |sys_take) begin
					// A request arriving in the same cycle wins over the clear
					r_next.sys_pend_reg[sys_lvl] = r_reg.sync2_reg[sys_lvl]; // RL18
					r_next.save_reg = r_reg.psw_reg;
					r_next.old_a_reg = PSA_SYS_OLD + 16'(sys_lvl) * PSA_SYS_STEP;
					r_next.new_a_reg = PSA_SYS_OLD + 16'(sys_lvl) * PSA_SYS_STEP + 16'h0004;
					r_next.cls_reg = CL_SYS;
					r_next.st_reg = ST_OLDHI;
					ev[EV_SYS] = 1'b1;
				end
			end
			// Old word is written in two halves before any fetch
			ST_OLDHI: if (MEM_ACK) r_next.st_reg = ST_OLDLO; // RL17 RL19
			ST_OLDLO: if (MEM_ACK) r_next.st_reg = ST_NEWHI; // RL19
			ST_NEWHI: begin
				if (MEM_ACK) begin
					r_next.psw_reg[63:32] = MEM_RDATA; // RL17
					r_next.st_reg = ST_NEWLO;
				end
			end
			ST_NEWLO: begin
				if (MEM_ACK) begin
					// New word may switch problem to supervisor state
					r_next.psw_reg[31:0] = MEM_RDATA; // RL16 RL17
					r_next.st_reg = ST_IDLE;
				end
			end
			ST_PUT: begin
				if (MEM_ACK) begin
					r_next.put_cnt_reg = r_reg.put_cnt_reg + 8'h01;
					if (r_reg.put_cnt_reg == PUTAWAY_WORDS - 8'h01) begin
						r_next.st_reg = ST_DOWN;
					end
				end
			end
			ST_DOWN: begin
				r_next.pwr_down_reg = 1'b1;
				r_next.st_reg = ST_IDLE;
			end
			default: r_next.st_reg = ST_IDLE;
		endcase
		// Register access; status cleared by read, set wins
		r_next.stat_reg = r_reg.stat_reg | ev;
		if (PSEL && !PENABLE && !PWRITE) begin
			case (PADDR)
				A_PSW_HI: r_next.rdata_reg = r_reg.psw_reg[63:32];
				A_PSW_LO: r_next.rdata_reg = r_reg.psw_reg[31:0];
				A_STATUS: r_next.rdata_reg = 32'(r_reg.stat_reg | ev);
				A_MASK: r_next.rdata_reg = 32'(r_reg.mask_reg);
				A_CTRL: r_next.rdata_reg = {31'h0, r_reg.pwr_down_reg};
				A_SYSPEND: r_next.rdata_reg = 32'(r_reg.sys_pend_reg);
				default: r_next.rdata_reg = 32'h0;
			endcase
		end
		if (apb_acc && !PWRITE && PADDR == A_STATUS) begin
			r_next.stat_reg = ev;
		end
		if (apb_acc && PWRITE && r_reg.st_reg == ST_IDLE) begin
			case (PADDR)
				A_PSW_HI: r_next.psw_reg[63:32] = PWDATA;
				A_PSW_LO: r_next.psw_reg[31:0] = PWDATA;
				A_MASK: r_next.mask_reg = PWDATA[EV_N-1:0];
				default: ;
			endcase
		end
		if (!RESETN) begin
			r_next = '0;
			r_next.st_reg = ST_IDLE;
			r_next.cls_reg = CL_MC;
			r_next.psw_reg = PSW_RESET;
			// Power is taken as good out of reset so no false loss follows
			r_next.sync1_reg[SYS_LEVELS] = 1'b1;
			r_next.sync2_reg[SYS_LEVELS] = 1'b1;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge CLK) begin
		if (CE || !RESETN) begin
			r_reg <= r_next;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		MEM_REQ = 1'b0;
		MEM_WE = 1'b0;
		MEM_ADDR = 16'h0;
		MEM_WDATA = 32'h0;
		case (r_reg.st_reg)
			ST_OLDHI: begin
				MEM_REQ = 1'b1;
				MEM_WE = 1'b1;
				MEM_ADDR = r_reg.old_a_reg;
				MEM_WDATA = r_reg.save_reg[63:32];
			end
			ST_OLDLO: begin
				MEM_REQ = 1'b1;
				MEM_WE = 1'b1;
				MEM_ADDR = r_reg.old_a_reg + 16'h0002;
				MEM_WDATA = r_reg.save_reg[31:0];
			end
			ST_NEWHI: begin
				MEM_REQ = 1'b1;
				MEM_ADDR = r_reg.new_a_reg;
			end
			ST_NEWLO: begin
				MEM_REQ = 1'b1;
				MEM_ADDR = r_reg.new_a_reg + 16'h0002;
			end
			default: ;
		endcase
	end

	assign CPU_WAIT = r_reg.psw_reg[pbit(BIT_WAIT)]; // RL1
	assign CPU_SUPERVISOR = ~r_reg.psw_reg[pbit(BIT_PROBLEM)]; // RL2
	assign PRIV_EXEC_OK = ~r_reg.psw_reg[pbit(BIT_PROBLEM)]; // RL2
	assign TERMINATE = r_reg.term_reg;
	assign PUTAWAY_REQ = (r_reg.st_reg == ST_PUT);
	assign PUTAWAY_ADDR = PSA_PUTAWAY + {8'h0, r_reg.put_cnt_reg};
	assign PRDATA = r_reg.rdata_reg;
	assign PREADY = 1'b1;
	assign PSLVERR = 1'b0;
	assign IRQ = |(r_reg.stat_reg & r_reg.mask_reg);

	// ****************************************
	// Checks
	// ****************************************
	chk_wait_bit: assert property (@(posedge CLK) disable iff (!RESETN) // RL1
		CPU_WAIT == r_reg.psw_reg[17]) else $error("wait output wrong");
	chk_priv_block: assert property (@(posedge CLK) disable iff (!RESETN) // RL3
		(PRIV_OP && !CPU_SUPERVISOR) |-> pgm_all[PC_PRIV]) else $error("privileged op passed");
	chk_mc_term: assert property (@(posedge CLK) disable iff (!RESETN) // RL7
		(CE && r_reg.st_reg == ST_IDLE && r_reg.pwr_down_reg == 1'b0 && pwr_good_s && mc_take)
		|=> TERMINATE && r_reg.st_reg == ST_OLDHI) else $error("machine check not taken");
	chk_mc_drop: assert property (@(posedge CLK) disable iff (!RESETN) // RL8
		(MALFUNCTION && !r_reg.psw_reg[20] && r_reg.st_reg == ST_IDLE) |=> !TERMINATE)
		else $error("masked machine check taken");
	chk_ovf_mask: assert property (@(posedge CLK) disable iff (!RESETN) // RL9
		!r_reg.psw_reg[43] |-> !pgm_take[PC_FXOVF]) else $error("overflow not masked");
	chk_mon_mask: assert property (@(posedge CLK) disable iff (!RESETN) // RL10
		!r_reg.psw_reg[29] |-> !pgm_take[PC_MON]) else $error("monitor not masked");
	chk_illegal_take: assert property (@(posedge CLK) disable iff (!RESETN) // RL13
		PGM_CAUSE[PC_ILLINST] |-> pgm_take[PC_ILLINST]) else $error("invalid op masked");
	chk_old_first: assert property (@(posedge CLK) disable iff (!RESETN) // RL19
		(r_reg.st_reg == ST_NEWHI) |-> $past(r_reg.st_reg) inside {ST_OLDLO, ST_NEWHI, ST_IDLE})
		else $error("fetch before store");
	chk_svc_code: assert property (@(posedge CLK) disable iff (!RESETN) // RL15
		(CE && r_reg.st_reg == ST_IDLE && r_next.cls_reg == CL_SVC && r_next.st_reg == ST_OLDHI)
		|=> r_reg.save_reg[15:0] == $past(SVC_EA[15:0])) else $error("call code wrong");
	chk_sys_pend: assert property (@(posedge CLK) disable iff (!RESETN) // RL18
		(CE && r_reg.sync2_reg[0] && r_reg.st_reg != ST_IDLE) |=> r_reg.sys_pend_reg[0])
		else $error("system request lost");
endmodule

//--- dv/psw_swap_unit_tb.sv
// Self-checking testbench for the status word swap unit
`timescale 1ns/1ns
module psw_swap_unit_tb
	import psw_pkg::*;
;
	// ****************************************
	// Signals and bench state
	// ****************************************
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic CE = 1'b1;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic IRQ;
	logic MALFUNCTION = 1'b0;
	logic [PC_N-1:0] PGM_CAUSE = 8'h00;
	logic PRIV_OP = 1'b0;
	logic SVC_EXEC = 1'b0;
	logic [18:0] SVC_EA = 19'h00000;
	logic ENDOP = 1'b1;
	logic POWER_GOOD = 1'b1;
	logic RUN_MODE = 1'b1;
	logic [SYS_LEVELS-1:0] SYS_REQ = 7'h00;
	logic CPU_WAIT;
	logic CPU_SUPERVISOR;
	logic PRIV_EXEC_OK;
	logic TERMINATE;
	logic PUTAWAY_REQ;
	logic [15:0] PUTAWAY_ADDR;
	logic MEM_REQ;
	logic MEM_WE;
	logic [15:0] MEM_ADDR;
	logic [31:0] MEM_WDATA;
	logic [31:0] MEM_RDATA;
	logic MEM_ACK;
	logic [31:0] mem [0:1023]; // Storage model, halfword addressed
	logic [16:0] acc [$]; // Log of storage accesses, {write, address}
	logic tog = 1'b0; // Storage answers every other cycle
	logic term_seen = 1'b0;
	logic [31:0] rd;
	logic [63:0] w;
	int n_mismatch = 0;
	int checks_done = 0;
	int pidx [7] = '{0, 1, 2, 3, 4, 6, 7}; // Program causes exercised
	int pen [7] = '{20, 22, 23, 34, 43, -1, -1}; // Enable bit of each, -1 none

	// Clock at 50 MHz
	always #10 CLK = ~CLK;

	// Storage: slow answer, log of accesses, terminate watch
	always @(posedge CLK) begin
		tog <= ~tog;
		if (TERMINATE === 1'b1) begin
			term_seen <= 1'b1;
		end
		if (MEM_REQ === 1'b1 && MEM_ACK === 1'b1) begin
			if (MEM_WE === 1'b1) begin
				mem[MEM_ADDR[9:0]] <= MEM_WDATA;
			end
			acc.push_back({MEM_WE, MEM_ADDR});
		end
	end
	// Storage also answers each putaway word
	assign MEM_ACK = (MEM_REQ | PUTAWAY_REQ) & tog;
	// Idle read lines show a changing pattern, never stale data
	assign MEM_RDATA = MEM_ACK ? mem[MEM_ADDR[9:0]] : (tog ? 32'h5a5aa5a5 : 32'ha5a55a5a);

	psw_swap_unit psw_swap_unit_i (.CLK(CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ), .MALFUNCTION(MALFUNCTION),
		.PGM_CAUSE(PGM_CAUSE), .PRIV_OP(PRIV_OP), .SVC_EXEC(SVC_EXEC), .SVC_EA(SVC_EA),
		.ENDOP(ENDOP), .POWER_GOOD(POWER_GOOD), .RUN_MODE(RUN_MODE), .SYS_REQ(SYS_REQ),
		.CPU_WAIT(CPU_WAIT), .CPU_SUPERVISOR(CPU_SUPERVISOR), .PRIV_EXEC_OK(PRIV_EXEC_OK),
		.TERMINATE(TERMINATE), .PUTAWAY_REQ(PUTAWAY_REQ), .PUTAWAY_ADDR(PUTAWAY_ADDR),
		.MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
		.MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));

	// ****************************************
	// Tasks
	// ****************************************
	// Prints the verdict and ends the run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
	endtask

	// One APB transfer; read data lands in rd
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 50);
		chk("pready", PREADY, 32'd1);
		chk("slverr", PSLVERR, 32'd0);
		rd = PRDATA;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
	endtask

	// Writes the whole status word, high half first
	task automatic setw(input logic [63:0] v);
		apb(1'b1, A_PSW_HI, v[63:32]);
		apb(1'b1, A_PSW_LO, v[31:0]);
	endtask

	// Places a new word in storage and clears the access log
	task automatic arm(input logic [15:0] na, input logic [63:0] nv);
		mem[na[9:0]] = nv[63:32];
		mem[na[9:0] + 10'd2] = nv[31:0];
		acc.delete();
	endtask

	// Waits for one swap and checks its order, old word and new word
	task automatic swap(input string nm, input logic [15:0] oa, input logic [15:0] na,
		input logic [63:0] ov, input logic [63:0] nv);
		int n;
		for (n = 0; n < 400 && acc.size() < 4; n++) @(posedge CLK);
		chk({nm, " count"}, acc.size(), 32'd4);
		if (acc.size() >= 4) begin
			chk({nm, " acc0"}, acc[0], {1'b1, oa});
			chk({nm, " acc1"}, acc[1], {1'b1, oa + 16'h2});
			chk({nm, " acc2"}, acc[2], {1'b0, na});
			chk({nm, " acc3"}, acc[3], {1'b0, na + 16'h2});
		end
		chk({nm, " old hi"}, mem[oa[9:0]], ov[63:32]);
		chk({nm, " old lo"}, mem[oa[9:0] + 10'd2], ov[31:0]);
		cyc(3);
		rchk({nm, " new hi"}, A_PSW_HI, nv[63:32]);
		rchk({nm, " new lo"}, A_PSW_LO, nv[31:0]);
		acc.delete();
	endtask

	// Expects no storage access for a while
	task automatic quiet(input string nm, input int n);
		cyc(n);
		chk(nm, acc.size(), 32'd0);
	endtask

	// Interrupt line up, status shows the class and clears on read
	task automatic stat(input string nm, input logic [31:0] exp);
		chk({nm, " irq"}, IRQ, 32'd1);
		rchk({nm, " status"}, A_STATUS, exp);
		rchk({nm, " cleared"}, A_STATUS, 32'h0);
	endtask

	task automatic pcause(input int i);
		@(posedge CLK);
		PGM_CAUSE <= 8'h01 << i;
		@(posedge CLK);
		PGM_CAUSE <= 8'h00;
	endtask

	// Status word bit n, bit 0 the most significant
	function automatic logic [63:0] db(input int n);
		return 64'h1 << (63 - n);
	endfunction

	function automatic logic [63:0] code(input logic [63:0] v, input logic [15:0] c);
		return {v[63:16], c};
	endfunction

	// ****************************************
	// Watchdog
	// ****************************************
	initial begin
		cyc(60000);
		n_mismatch++;
		end_of_test();
	end

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		for (int i = 0; i < 1024; i++) mem[i] = 32'h0;
		cyc(5);
		RESETN <= 1'b1;
		// Reset values and register access
		rchk("word hi", A_PSW_HI, 32'h0);
		rchk("word lo", A_PSW_LO, 32'h0);
		rchk("ctrl", A_CTRL, 32'h0);
		chk("wait", CPU_WAIT, 32'd0);
		chk("supervisor", CPU_SUPERVISOR, 32'd1);
		apb(1'b1, 8'h20, 32'hffffffff);
		rchk("unmapped", 8'h20, 32'h0);
		apb(1'b1, A_MASK, 32'h1f);
		rchk("mask", A_MASK, 32'h1f);
		// Clock enable low freezes state, so this write is lost
		CE <= 1'b0;
		apb(1'b1, A_MASK, 32'h00);
		CE <= 1'b1;
		rchk("frozen", A_MASK, 32'h1f);
		$display("test reset done");
		// Wait and problem state bits
		setw(db(46) | db(47));
		cyc(2);
		chk("wait set", CPU_WAIT, 32'd1);
		chk("problem", CPU_SUPERVISOR, 32'd0);
		chk("priv blocked", PRIV_EXEC_OK, 32'd0);
		// Privileged attempt in problem state traps
		w = db(47) | db(43);
		setw(w);
		cyc(1);
		chk("run", CPU_WAIT, 32'd0);
		arm(PSA_PGM_NEW, db(43));
		@(posedge CLK);
		PRIV_OP <= 1'b1;
		@(posedge CLK);
		PRIV_OP <= 1'b0;
		swap("priv", PSA_PGM_OLD, PSA_PGM_NEW, code(w, CODE_PGM_BASE + 16'(PC_PRIV)), db(43));
		chk("priv ok", PRIV_EXEC_OK, 32'd1);
		stat("priv", 32'h2);
		@(posedge CLK);
		PRIV_OP <= 1'b1;
		@(posedge CLK);
		PRIV_OP <= 1'b0;
		quiet("priv in supervisor", 20);
		$display("test state done");
		// Supervisor call from problem state
		w = db(47) | db(43);
		setw(w);
		arm(PSA_SVC_NEW, db(43));
		@(posedge CLK);
		SVC_EA <= 19'h5abcd;
		SVC_EXEC <= 1'b1;
		@(posedge CLK);
		SVC_EXEC <= 1'b0;
		swap("svc", PSA_SVC_OLD, PSA_SVC_NEW, {w[63:24], 4'hb, w[19:16], 16'habcd}, db(43));
		chk("svc supervisor", CPU_SUPERVISOR, 32'd1);
		stat("svc", 32'h4);
		$display("test svc done");
		// Machine check taken, then discarded while masked
		w = db(43);
		setw(w);
		arm(PSA_MC_NEW, 64'h0);
		term_seen = 1'b0;
		@(posedge CLK);
		MALFUNCTION <= 1'b1;
		@(posedge CLK);
		MALFUNCTION <= 1'b0;
		swap("mc", PSA_MC_OLD, PSA_MC_NEW, code(w, CODE_MC), 64'h0);
		chk("terminate", term_seen, 32'd1);
		stat("mc", 32'h1);
		@(posedge CLK);
		MALFUNCTION <= 1'b1;
		@(posedge CLK);
		MALFUNCTION <= 1'b0;
		quiet("mc masked", 20);
		setw(db(43));
		quiet("mc not pending", 20);
		$display("test mc done");
		// Program causes: dropped while masked, taken when enabled or unmaskable
		for (int k = 0; k < 7; k++) begin
			w = (pen[k] < 0) ? 64'h0 : db(pen[k]);
			if (pen[k] >= 0) begin
				setw(64'h0);
				acc.delete();
				pcause(pidx[k]);
				quiet("pgm masked", 20);
			end
			setw(w);
			arm(PSA_PGM_NEW, w);
			pcause(pidx[k]);
			swap("pgm", PSA_PGM_OLD, PSA_PGM_NEW, code(w, 16'(pidx[k])), w);
			stat("pgm", 32'h2);
		end
		$display("test program done");
		// System request held pending until its mask opens
		setw(64'h0);
		arm(PSA_SYS_OLD + 16'h4, 64'h0);
		@(posedge CLK);
		SYS_REQ <= 7'h01;
		cyc(4);
		SYS_REQ <= 7'h00;
		cyc(6);
		rchk("sys pending", A_SYSPEND, 32'h1);
		quiet("sys masked", 10);
		w = db(32);
		setw(w);
		swap("sys", PSA_SYS_OLD, PSA_SYS_OLD + 16'h4, w, 64'h0);
		rchk("sys served", A_SYSPEND, 32'h0);
		stat("sys", 32'h8);
		$display("test system done");
		// Power loss saves state, power return loads the power-on word
		@(posedge CLK);
		POWER_GOOD <= 1'b0;
		for (int n = 0; n < 100 && PUTAWAY_REQ !== 1'b1; n++) @(posedge CLK);
		chk("putaway req", PUTAWAY_REQ, 32'd1);
		chk("putaway addr", PUTAWAY_ADDR, PSA_PUTAWAY);
		for (int n = 0; n < 1000 && PUTAWAY_REQ !== 1'b0; n++) @(posedge CLK);
		rchk("powered down", A_CTRL, 32'h1);
		arm(PSA_PWR_ON, {32'h00001234, 32'h00100000});
		@(posedge CLK);
		RUN_MODE <= 1'b0;
		POWER_GOOD <= 1'b1;
		quiet("power-on held", 20);
		RUN_MODE <= 1'b1;
		for (int n = 0; n < 200 && acc.size() < 2; n++) @(posedge CLK);
		chk("power-on fetch", acc.size() > 0 ? acc[0] : 17'h1ffff, {1'b0, PSA_PWR_ON});
		cyc(3);
		rchk("power-on hi", A_PSW_HI, 32'h00001234);
		rchk("power-on lo", A_PSW_LO, 32'h00100000);
		$display("test power done");
		end_of_test();
	end
endmodule
